/* rtl/atfc_control.v */
// converter control, result formatting, auto trigger and pin input disable with apb registers
//
// How it works
// - gain stage unipolar after reset, bit 7 selects bipolar
// - unipolar negative difference saturates to full scale
// - bipolar result is coded in two's complement
// - ten bits unipolar, nine plus sign bipolar
// - left adjust bit selects result alignment
// - alignment change shows immediately, even mid conversion
// - reserved bit 3 reads back last write
// - trigger field matters only with auto trigger
// - auto trigger starts on selected flag rising
// - switching from a clear to a set flag is an edge
// - switching to free running never triggers
// - trigger field encodes eight sources, zero free-running
// - disable bit turns pin input buffer off
// - disabled pin reads zero in port input
// - result register pair holds ten result bits
// - auto enable starts conversions on trigger edges
// - done flag sets on update, clears by ack/one
// - low byte read locks pair until high read
// - byte placement of result for each alignment
`timescale 1ns/100ps
`include "atfc_defs.vh"

module atfc_control (
  input  wire                   pclk,
  input  wire                   presetn,
  // apb slave
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`ATFC_AW-1:0]    paddr,
  input  wire [31:0]            pwdata,
  output wire                   pready,
  output wire                   pslverr,
  output reg  [31:0]            prdata,
  // converter core
  output reg                    conv_start,
  output wire                   conv_enable,
  output wire                   bipolar_mode,
  output wire [2:0]             prescale_sel,
  input  wire                   conv_done,
  input  wire [9:0]             conv_code,
  input  wire                   conv_neg,
  // peripheral flags and interrupt acknowledge
  input  wire [7:1]             trig_flags,
  input  wire                   done_vector_ack,
  output wire                   conversion_done_flag,
  // analog pins
  input  wire [7:0]             pin_in,
  output wire [7:0]             pin_buf_disable,
  output reg  [7:0]             pin_value
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------

  // turn the raw code into the stored result for the chosen mode
  function [9:0] fmt_result;
    input       bip;
    input       neg;
    input [9:0] code;
    reg   [8:0] mag;
    begin
      mag = code[9:1];
      if (bip) begin
        if (neg) begin
          fmt_result = 10'h000 - {1'b0, mag};
        end else begin
          fmt_result = {1'b0, mag};
        end
      end else if (neg) begin
        fmt_result = `ATFC_FULL_SCALE;
      end else begin
        fmt_result = code;
      end
    end
  endfunction

  // register index match for an aligned word
  function idx_hit;
    input [`ATFC_AW-1:0] addr;
    input [7:0]          idx;
    begin
      idx_hit = (addr[`ATFC_AW-1:2] == {2'h0, idx});
    end
  endfunction

  // ------------------------------------------------------------
  // registers and wires
  // ------------------------------------------------------------

  // one-hot conversion states
  localparam ST_IDLE = 2'b01;
  localparam ST_BUSY = 2'b10;

  reg  [7:0] pin_dis_r;
  reg  [7:0] ctrl_b_r;
  reg        enable_r;
  reg        auto_r;
  reg        done_r;
  reg  [1:0] conv_state_r;
  reg  [1:0] conv_state_nxt;
  reg  [3:0] ctrl_a_low_r;
  reg  [9:0] result_r;
  reg        lock_r;
  reg  [7:0] pin_s1_r;
  reg  [7:0] pin_s2_r;
  reg  [7:0] pin_s3_r;
  reg  [7:0] pin_stable_r;

  wire       setup_cyc;
  wire       access_cyc;
  wire       wr_acc;
  wire       rd_acc;
  wire       mapped;
  wire       hit_pin_dis;
  wire       hit_ctrl_b;
  wire       hit_res_low;
  wire       hit_res_high;
  wire       hit_ctrl_a;
  wire       hit_pin_val;
  wire       left_adj;
  wire [7:0] res_low;
  wire [7:0] res_high;
  wire       trig_edge;
  wire       auto_start;
  wire       sw_start;
  wire       start_now;
  wire       low_rd_pending;
  wire       update_ok;
  wire       done_clr;
  wire       busy;
  wire       conv_off;
  wire [7:0] pin_agree;
  wire [7:0] ctrl_a_view;
  reg  [7:0] rd_byte;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------

  assign setup_cyc  = psel & ~penable;
  assign access_cyc = psel & penable;
  assign wr_acc     = access_cyc & pwrite & mapped;
  assign rd_acc     = access_cyc & ~pwrite & mapped;

  assign hit_pin_dis  = idx_hit(paddr, `ATFC_IDX_PIN_DIS);
  assign hit_ctrl_b   = idx_hit(paddr, `ATFC_IDX_CTRL_B);
  assign hit_res_low  = idx_hit(paddr, `ATFC_IDX_RES_LOW);
  assign hit_res_high = idx_hit(paddr, `ATFC_IDX_RES_HIGH);
  assign hit_ctrl_a   = idx_hit(paddr, `ATFC_IDX_CTRL_A);
  assign hit_pin_val  = idx_hit(paddr, `ATFC_IDX_PIN_VALUE);

  assign mapped = hit_pin_dis | hit_ctrl_b | hit_res_low | hit_res_high | hit_ctrl_a | hit_pin_val;

  // no wait states; read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access_cyc & ~mapped;

  // ------------------------------------------------------------
  // control register b
  // ------------------------------------------------------------

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_b_r <= `ATFC_RST_CTRL_B;
    end else if (wr_acc && hit_ctrl_b) begin
      ctrl_b_r <= pwdata[7:0];
    end
  end

  assign bipolar_mode = ctrl_b_r[`ATFC_B_BIPOLAR];
  assign left_adj     = ctrl_b_r[`ATFC_B_LEFT_ADJ];

  // ------------------------------------------------------------
  // pin input disable and port input view
  // ------------------------------------------------------------

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_dis_r <= `ATFC_RST_PIN_DIS;
    end else if (wr_acc && hit_pin_dis) begin
      pin_dis_r <= pwdata[7:0];
    end
  end

  assign pin_buf_disable = pin_dis_r;

  // pins are asynchronous; a level is taken once stages two and three agree
  assign pin_agree = ~(pin_s2_r ^ pin_s3_r);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r     <= 8'h00;
      pin_s2_r     <= 8'h00;
      pin_s3_r     <= 8'h00;
      pin_stable_r <= 8'h00;
      pin_value    <= 8'h00;
    end else begin
      pin_s1_r     <= pin_in;
      pin_s2_r     <= pin_s1_r;
      pin_s3_r     <= pin_s2_r;
      pin_stable_r <= (pin_s3_r & pin_agree) | (pin_stable_r & ~pin_agree);
      pin_value    <= pin_stable_r & ~pin_dis_r;
    end
  end

  // ------------------------------------------------------------
  // trigger selection
  // ------------------------------------------------------------

  atfc_trigger_sel u_trig (
    .pclk       (pclk),
    .presetn    (presetn),
    .trig_sel   (ctrl_b_r[`ATFC_B_TRIG_HI:`ATFC_B_TRIG_LO]),
    .trig_flags (trig_flags),
    .done_flag  (done_r),
    .trig_edge  (trig_edge)
  );

  // edges are ignored unless auto mode and the converter are on
  assign auto_start = trig_edge & auto_r & enable_r & ~busy;
  assign sw_start   = wr_acc & hit_ctrl_a & pwdata[`ATFC_A_START] & pwdata[`ATFC_A_ENABLE] & ~busy;
  assign start_now  = auto_start | sw_start;
  assign conv_off   = wr_acc & hit_ctrl_a & ~pwdata[`ATFC_A_ENABLE];

  // ------------------------------------------------------------
  // control register a and conversion sequencing
  // ------------------------------------------------------------

  assign done_clr = (wr_acc & hit_ctrl_a & pwdata[`ATFC_A_DONE]) | done_vector_ack;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r     <= 1'b0;
      auto_r       <= 1'b0;
      ctrl_a_low_r <= 4'h0;
      conv_state_r <= ST_IDLE;
      conv_start   <= 1'b0;
    end else begin
      conv_state_r <= conv_state_nxt;
      conv_start   <= start_now;
      if (wr_acc && hit_ctrl_a) begin
        enable_r     <= pwdata[`ATFC_A_ENABLE];
        auto_r       <= pwdata[`ATFC_A_AUTO];
        ctrl_a_low_r <= pwdata[`ATFC_A_STORE_HI:0];
      end
    end
  end

  // switching the converter off ends a running conversion
  always @* begin
    conv_state_nxt = conv_state_r;
    case (conv_state_r)
      ST_IDLE: begin
        if (start_now && !conv_off) begin
          conv_state_nxt = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (conv_off || conv_done) begin
          conv_state_nxt = ST_IDLE;
        end
      end
      default: begin
        conv_state_nxt = ST_IDLE;
      end
    endcase
  end

  assign busy         = (conv_state_r == ST_BUSY);
  assign conv_enable  = enable_r;
  assign prescale_sel = ctrl_a_low_r[2:0];

  // ------------------------------------------------------------
  // result register pair and done flag
  // ------------------------------------------------------------

  // a low byte read in its setup cycle already holds off the update
  assign low_rd_pending = setup_cyc & ~pwrite & hit_res_low;
  assign update_ok      = conv_done & busy & ~lock_r & ~low_rd_pending;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_r <= 10'h000;
      lock_r   <= 1'b0;
      done_r   <= 1'b0;
    end else begin
      if (update_ok) begin
        result_r <= fmt_result(bipolar_mode, conv_neg, conv_code);
      end
      if (rd_acc && hit_res_low) begin
        lock_r <= 1'b1;
      end else if (rd_acc && hit_res_high) begin
        lock_r <= 1'b0;
      end
      // a completion in the clearing cycle keeps the flag set
      if (update_ok) begin
        done_r <= 1'b1;
      end else if (done_clr) begin
        done_r <= 1'b0;
      end
    end
  end

  assign conversion_done_flag = done_r;

  // alignment is applied on the way out, so it follows the bit at once
  assign res_high = left_adj ? result_r[9:2] : {6'h00, result_r[9:8]};
  assign res_low  = left_adj ? {result_r[1:0], 6'h00} : result_r[7:0];

  assign ctrl_a_view = {enable_r, busy, auto_r, done_r, ctrl_a_low_r};

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------

  always @* begin
    rd_byte = 8'h00;
    case (1'b1)
      hit_pin_dis:  rd_byte = pin_dis_r;
      hit_ctrl_b:   rd_byte = ctrl_b_r;
      hit_res_low:  rd_byte = res_low;
      hit_res_high: rd_byte = res_high;
      hit_ctrl_a:   rd_byte = ctrl_a_view;
      hit_pin_val:  rd_byte = pin_value;
      default:      rd_byte = 8'h00;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_cyc && !pwrite) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

endmodule

/* rtl/atfc_defs.vh */
// register map, field positions and reset values of the trigger and format control block
`ifndef ATFC_DEFS_VH
`define ATFC_DEFS_VH

// register indices; byte address is four times the index
`define ATFC_IDX_PIN_DIS    8'h01
`define ATFC_IDX_CTRL_B     8'h03
`define ATFC_IDX_RES_LOW    8'h04
`define ATFC_IDX_RES_HIGH   8'h05
`define ATFC_IDX_CTRL_A     8'h06
`define ATFC_IDX_PIN_VALUE  8'h08

// apb address width
`define ATFC_AW             12

// reset values
`define ATFC_RST_PIN_DIS    8'h00
`define ATFC_RST_CTRL_B     8'h00
`define ATFC_RST_CTRL_A     8'h00

// converter_control_b fields
`define ATFC_B_BIPOLAR      7
`define ATFC_B_LEFT_ADJ     4
`define ATFC_B_TRIG_HI      2
`define ATFC_B_TRIG_LO      0

// converter_control_a fields
`define ATFC_A_ENABLE       7
`define ATFC_A_START        6
`define ATFC_A_AUTO         5
`define ATFC_A_DONE         4
`define ATFC_A_STORE_HI     3

// trigger source codes
`define ATFC_TRIG_FREE      3'h0

// full scale of the 10-bit result
`define ATFC_FULL_SCALE     10'h3FF

`endif

/* rtl/atfc_trigger_sel.v */
// trigger source selection and rising-edge detection
`timescale 1ns/100ps
`include "atfc_defs.vh"

module atfc_trigger_sel (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [2:0] trig_sel,
  input  wire [7:1] trig_flags,
  input  wire       done_flag,
  output wire       trig_edge
);

  reg  [2:0] sel_prev_r;
  reg        level_prev_r;
  wire [7:0] src_level;
  wire       level_cur;
  wire       to_free;

  // source zero follows the converter's own done flag
  assign src_level = {trig_flags, done_flag};
  assign level_cur = src_level[trig_sel];

  // entering free running never counts as an edge
  assign to_free = (trig_sel == `ATFC_TRIG_FREE) && (sel_prev_r != `ATFC_TRIG_FREE);

  // a switch from a clear flag to a set one is an edge as well
  assign trig_edge = level_cur & ~level_prev_r & ~to_free;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_prev_r   <= 3'h0;
      level_prev_r <= 1'b0;
    end else begin
      sel_prev_r   <= trig_sel;
      level_prev_r <= level_cur;
    end
  end

endmodule

/* test/atfc_control_sva.sv */
// assertion checker for the trigger and format control block
`timescale 1ns/100ps
`include "atfc_defs.vh"
module atfc_control_sva (
  input wire                pclk,
  input wire                presetn,
  input wire                psel,
  input wire                penable,
  input wire                pwrite,
  input wire [`ATFC_AW-1:0] paddr,
  input wire [31:0]         pwdata,
  input wire                pslverr,
  input wire                conv_start,
  input wire                conv_enable,
  input wire                bipolar_mode,
  input wire                conv_done,
  input wire                done_vector_ack,
  input wire                conversion_done_flag,
  input wire [7:0]          pin_buf_disable,
  input wire [7:0]          pin_value
);
  wire [9:0] idx  = paddr[`ATFC_AW-1:2];
  wire       acc  = psel && penable;
  wire       wr_b = acc && pwrite && idx == 10'h003;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr_b; wr_b; endsequence
  sequence s_ack; conversion_done_flag && done_vector_ack && !conv_done; endsequence
  chk_unmap_err: assert property (acc |-> pslverr == !(idx inside {10'h001, 10'h003, 10'h004, 10'h005, 10'h006, 10'h008}))
    else $error("slave error does not match address map");
  chk_bip_write: assert property (s_wr_b |=> bipolar_mode == $past(pwdata[7]))
    else $error("bipolar mode not taken from write");
  chk_bip_keep: assert property ($changed(bipolar_mode) |-> $past(wr_b))
    else $error("bipolar mode changed without write");
  chk_pin_zero: assert property ((pin_value & pin_buf_disable & $past(pin_buf_disable)) == 8'h00)
    else $error("disabled pin reads nonzero");
  chk_start_one: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  chk_start_en: assert property ($rose(conv_start) |-> conv_enable || $past(conv_enable))
    else $error("start while converter disabled");
  chk_done_src: assert property ($rose(conversion_done_flag) |-> $past(conv_done))
    else $error("done flag set without conversion end");
  chk_done_ack: assert property (s_ack |=> !conversion_done_flag)
    else $error("done flag not cleared by acknowledge");
endmodule
bind atfc_control atfc_control_sva u_sva (.*);

/* test/adc_trigger_format_control_bench.sv */
// self-checking bench for the trigger and format control block
`timescale 1ns/100ps
`include "atfc_defs.vh"
module adc_trigger_format_control_bench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        conv_done = 0, conv_neg = 0, done_vector_ack = 0;
  logic        pready, pslverr, conv_start, conv_enable, bipolar_mode, conversion_done_flag;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, fails = 0, n_tests = 0, n_start = 0, cyc = 0, k;
  logic [9:0]  conv_code = 10'h000, r;
  logic [7:1]  trig_flags = 7'h00;
  logic [7:0]  pin_in = 8'h00, pin_buf_disable, pin_value, v, d;
  logic [2:0]  prescale_sel;
  logic [31:0] exq[$];
  integer      seed = 9, i;
  always #5 pclk = ~pclk;
  atfc_control dut (.*);
  // ----------------------------------------
  // bus, conversion and checking tasks
  // ----------------------------------------
  task chk(input [31:0] s, input [31:0] e);
    n_tests = n_tests + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task apb(input [11:0] a, input w, input [7:0] wd, input [7:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, wd};
    if (!w) exq.push_back({24'h0, e});
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task go;
    @(posedge pclk);
    while (conv_start !== 1'b1) @(posedge pclk);
  endtask
  task fin(input [9:0] c, input n);
    @(posedge pclk);
    conv_code <= c;
    conv_neg <= n;
    conv_done <= 1'b1;
    @(posedge pclk);
    conv_done <= 1'b0;
    #1;
  endtask
  task wait_n(input [31:0] e);
    repeat (5) @(posedge pclk);
    #1;
    chk(n_start - k, e);
  endtask
  function [9:0] res(input b, input n, input [9:0] c);
    res = b ? (n ? 10'h000 - {1'b0, c[9:1]} : {1'b0, c[9:1]}) : (n ? `ATFC_FULL_SCALE : c);
  endfunction
  task rd_pair(input [9:0] x, input l);
    apb(12'h010, 1'b0, 8'h00, l ? {x[1:0], 6'h00} : x[7:0]);
    apb(12'h014, 1'b0, 8'h00, l ? x[9:2] : {6'h00, x[9:8]});
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (conv_start === 1'b1) n_start <= n_start + 1;
    if (psel && penable && pready === 1'b1 && !pwrite) chk(prdata, exq.pop_front());
    if (cyc == 32'd20000) begin
      fails = fails + 1;
      test_done;
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(12'h004, 1'b0, 8'h00, `ATFC_RST_PIN_DIS);
    apb(12'h00C, 1'b0, 8'h00, `ATFC_RST_CTRL_B);
    chk(bipolar_mode, 32'h0);
    apb(12'h008, 1'b0, 8'h00, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      v = $random(seed);
      v[5] = 1'b0;
      apb(12'h00C, 1'b1, v, 8'h00);
      apb(12'h00C, 1'b0, 8'h00, v);
      chk(bipolar_mode, v[7]);
      d = $random(seed);
      apb(12'h004, 1'b1, d, 8'h00);
      chk(pin_buf_disable, d);
      @(posedge pclk);
      pin_in <= $random(seed);
      repeat (8) @(posedge pclk);
      apb(12'h020, 1'b0, 8'h00, pin_in & ~d);
    end
    apb(12'h004, 1'b1, 8'hFF, 8'h00);
    apb(12'h020, 1'b0, 8'h00, 8'h00);
    $display("registers done");
    for (i = 0; i < 4; i = i + 1) begin
      r = $random(seed);
      apb(12'h00C, 1'b1, {i[1], 7'h00}, 8'h00);
      apb(12'h018, 1'b1, 8'hC0, 8'h00);
      go;
      apb(12'h00C, 1'b1, {i[1], 7'h10}, 8'h00);
      fin(r, i[0]);
      chk(conversion_done_flag, 32'h1);
      rd_pair(res(i[1], i[0], r), 1'b1);
      apb(12'h00C, 1'b1, {i[1], 7'h00}, 8'h00);
      rd_pair(res(i[1], i[0], r), 1'b0);
      apb(12'h018, 1'b1, 8'h90, 8'h00);
      chk(conversion_done_flag, 32'h0);
    end
    apb(12'h00C, 1'b1, 8'h00, 8'h00);
    apb(12'h018, 1'b1, 8'hC0, 8'h00);
    go;
    fin(10'h155, 1'b0);
    @(posedge pclk);
    done_vector_ack <= 1'b1;
    @(posedge pclk);
    done_vector_ack <= 1'b0;
    #1;
    chk(conversion_done_flag, 32'h0);
    apb(12'h010, 1'b0, 8'h00, 8'h55);
    apb(12'h018, 1'b1, 8'hC0, 8'h00);
    go;
    fin(10'h2AA, 1'b0);
    chk(conversion_done_flag, 32'h0);
    apb(12'h014, 1'b0, 8'h00, 8'h01);
    rd_pair(10'h155, 1'b0);
    $display("conversions done");
    apb(12'h018, 1'b1, 8'hA5, 8'h00);
    chk(prescale_sel, 32'h5);
    apb(12'h018, 1'b0, 8'h00, 8'hA5);
    for (i = 1; i < 8; i = i + 1) begin
      apb(12'h00C, 1'b1, i[7:0], 8'h00);
      k = n_start;
      @(posedge pclk);
      trig_flags[i] <= 1'b1;
      wait_n(32'h1);
      fin(10'h000, 1'b0);
      wait_n(32'h1);
      @(posedge pclk);
      trig_flags[i] <= 1'b0;
    end
    apb(12'h018, 1'b1, 8'h90, 8'h00);
    apb(12'h00C, 1'b1, 8'h02, 8'h00);
    k = n_start;
    @(posedge pclk);
    trig_flags[2] <= 1'b1;
    wait_n(32'h0);
    apb(12'h00C, 1'b1, 8'h01, 8'h00);
    apb(12'h018, 1'b1, 8'hA0, 8'h00);
    k = n_start;
    apb(12'h00C, 1'b1, 8'h02, 8'h00);
    wait_n(32'h1);
    fin(10'h000, 1'b0);
    @(posedge pclk);
    trig_flags[2] <= 1'b0;
    k = n_start;
    apb(12'h00C, 1'b1, 8'h00, 8'h00);
    wait_n(32'h0);
    chk(conversion_done_flag, 32'h1);
    $display("triggers done");
    test_done;
  end
endmodule
